// >>> logic/srd_pkg.sv
// package: constants and types for the standby-release detect configuration block
package srd_pkg;
   localparam int          NUM_CH          = 4;
   localparam int          ADDR_W          = 8;
   localparam int          DATA_W          = 32;
   // register byte addresses
   localparam logic [7:0]  OFS_DETECT_CTRL = 8'h00;
   localparam logic [7:0]  OFS_PEND_STATUS = 8'h04;
   localparam logic [7:0]  OFS_PEND_MASK   = 8'h08;
   localparam logic [7:0]  OFS_CLEAR       = 8'h0C;
   // per-channel field layout inside one byte lane
   localparam int          LANE_W          = 8;
   localparam int          MODE_LSB        = 4;
   localparam int          STAT_LSB        = 2;
   localparam int          UNDEF_BIT       = 1;
   localparam int          EN_BIT          = 0;
   // detection mode codes
   localparam logic [2:0]  MODE_LOW        = 3'h0;
   localparam logic [2:0]  MODE_HIGH       = 3'h1;
   localparam logic [2:0]  MODE_FALL       = 3'h2;
   localparam logic [2:0]  MODE_RISE       = 3'h3;
   localparam logic [2:0]  MODE_BOTH       = 3'h4;
   localparam logic [2:0]  MODE_RESET      = MODE_FALL;
   // detected-edge codes
   localparam logic [1:0]  EDGE_NONE       = 2'h0;
   localparam logic [1:0]  EDGE_RISE       = 2'h1;
   localparam logic [1:0]  EDGE_FALL       = 2'h2;
   localparam logic [1:0]  EDGE_BOTH       = 2'h3;
   // value driven onto the undefined bit
   localparam logic        UNDEF_VALUE     = 1'b0;
   localparam logic [1:0]  RESP_OKAY       = 2'h0;
   localparam logic [1:0]  RESP_SLVERR     = 2'h2;

   typedef enum logic [1:0] {
      ST_IDLE,
      ST_RESP
   } srd_bus_state_t;
endpackage

// >>> logic/srd_edge_det.sv
// per-channel level/edge detector with detected-edge record
`timescale 1ns/100ps
module srd_edge_det
   import srd_pkg::*;
(
   input  wire logic       clock_i,
   input  wire logic       rst_b_i,
   input  wire logic       pin_i,
   input  wire logic [2:0] mode_i,
   input  wire logic       enable_i,
   input  wire logic       clear_i,
   output logic            request_o,
   output logic [1:0]      edge_o
);
   logic       prev_reg;
   logic       prev_next;
   logic [1:0] edge_reg;
   logic [1:0] edge_next;
   logic       rise;
   logic       fall;
   logic       hit;

   always_comb begin
      rise      = pin_i & ~prev_reg;
      fall      = ~pin_i & prev_reg;
      prev_next = pin_i;
      unique case (mode_i)
         MODE_LOW:  hit = ~pin_i;
         MODE_HIGH: hit = pin_i;
         MODE_FALL: hit = fall;
         MODE_RISE: hit = rise;
         MODE_BOTH: hit = rise | fall;
         default:   hit = 1'b0;                             // prohibited codes detect nothing
      endcase
      request_o = hit & enable_i;
      edge_next = edge_reg;
      // record only in both-edge mode; other modes leave stale content
      if (enable_i && mode_i == MODE_BOTH) begin
         edge_next = edge_reg | {fall, rise};
      end
      if (clear_i) begin
         edge_next = EDGE_NONE;
         if (enable_i && mode_i == MODE_BOTH) begin
            edge_next = {fall, rise};                       // a new edge wins over the clear
         end
      end
   end

   always_ff @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         prev_reg <= 1'b0;
         edge_reg <= EDGE_NONE;
      end else begin
         prev_reg <= prev_next;
         edge_reg <= edge_next;
      end
   end

   assign edge_o = edge_reg;
endmodule

// >>> logic/srd_axil_slave.sv
// AXI4-Lite slave front end: one write and one read at a time
`timescale 1ns/100ps
module srd_axil_slave
   import srd_pkg::*;
(
   input  wire logic                clock_i,
   input  wire logic                rst_b_i,
   input  wire logic [ADDR_W-1:0]   s_axi_awaddr,
   input  wire logic                s_axi_awvalid,
   output logic                     s_axi_awready,
   input  wire logic [DATA_W-1:0]   s_axi_wdata,
   input  wire logic [3:0]          s_axi_wstrb,
   input  wire logic                s_axi_wvalid,
   output logic                     s_axi_wready,
   output logic [1:0]               s_axi_bresp,
   output logic                     s_axi_bvalid,
   input  wire logic                s_axi_bready,
   input  wire logic [ADDR_W-1:0]   s_axi_araddr,
   input  wire logic                s_axi_arvalid,
   output logic                     s_axi_arready,
   output logic [DATA_W-1:0]        s_axi_rdata,
   output logic [1:0]               s_axi_rresp,
   output logic                     s_axi_rvalid,
   input  wire logic                s_axi_rready,
   output logic                     wr_en_o,
   output logic [ADDR_W-1:0]        wr_addr_o,
   output logic [DATA_W-1:0]        wr_data_o,
   output logic [3:0]               wr_strb_o,
   input  wire logic                wr_ok_i,
   output logic [ADDR_W-1:0]        rd_addr_o,
   input  wire logic [DATA_W-1:0]   rd_data_i,
   input  wire logic                rd_ok_i
);
   logic                aw_have_reg,  aw_have_next;
   logic                w_have_reg,   w_have_next;
   logic [ADDR_W-1:0]   awaddr_reg,   awaddr_next;
   logic [DATA_W-1:0]   wdata_reg,    wdata_next;
   logic [3:0]          wstrb_reg,    wstrb_next;
   logic                bvalid_reg,   bvalid_next;
   logic [1:0]          bresp_reg,    bresp_next;
   logic                rvalid_reg,   rvalid_next;
   logic [1:0]          rresp_reg,    rresp_next;
   logic [DATA_W-1:0]   rdata_reg,    rdata_next;

   always_comb begin
      s_axi_awready = ~aw_have_reg & ~bvalid_reg;
      s_axi_wready  = ~w_have_reg & ~bvalid_reg;
      s_axi_arready = ~rvalid_reg;
      aw_have_next  = aw_have_reg;
      w_have_next   = w_have_reg;
      awaddr_next   = awaddr_reg;
      wdata_next    = wdata_reg;
      wstrb_next    = wstrb_reg;
      bvalid_next   = bvalid_reg;
      bresp_next    = bresp_reg;
      rvalid_next   = rvalid_reg;
      rresp_next    = rresp_reg;
      rdata_next    = rdata_reg;
      if (s_axi_awvalid && s_axi_awready) begin
         aw_have_next = 1'b1;
         awaddr_next  = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         w_have_next = 1'b1;
         wdata_next  = s_axi_wdata;
         wstrb_next  = s_axi_wstrb;
      end
      wr_en_o   = aw_have_reg & w_have_reg;
      wr_addr_o = awaddr_reg;
      wr_data_o = wdata_reg;
      wr_strb_o = wstrb_reg;
      if (wr_en_o) begin
         aw_have_next = 1'b0;
         w_have_next  = 1'b0;
         bvalid_next  = 1'b1;
         bresp_next   = wr_ok_i ? RESP_OKAY : RESP_SLVERR;
      end
      if (bvalid_reg && s_axi_bready) begin
         bvalid_next = 1'b0;
      end
      rd_addr_o = s_axi_araddr;
      if (s_axi_arvalid && s_axi_arready) begin
         rvalid_next = 1'b1;
         rdata_next  = rd_ok_i ? rd_data_i : '0;
         rresp_next  = rd_ok_i ? RESP_OKAY : RESP_SLVERR;
      end else if (rvalid_reg && s_axi_rready) begin
         rvalid_next = 1'b0;
      end
   end

   always_ff @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         aw_have_reg <= 1'b0;
         w_have_reg  <= 1'b0;
         awaddr_reg  <= '0;
         wdata_reg   <= '0;
         wstrb_reg   <= '0;
         bvalid_reg  <= 1'b0;
         bresp_reg   <= RESP_OKAY;
         rvalid_reg  <= 1'b0;
         rresp_reg   <= RESP_OKAY;
         rdata_reg   <= '0;
      end else begin
         aw_have_reg <= aw_have_next;
         w_have_reg  <= w_have_next;
         awaddr_reg  <= awaddr_next;
         wdata_reg   <= wdata_next;
         wstrb_reg   <= wstrb_next;
         bvalid_reg  <= bvalid_next;
         bresp_reg   <= bresp_next;
         rvalid_reg  <= rvalid_next;
         rresp_reg   <= rresp_next;
         rdata_reg   <= rdata_next;
      end
   end

   assign s_axi_bvalid = bvalid_reg;
   assign s_axi_bresp  = bresp_reg;
   assign s_axi_rvalid = rvalid_reg;
   assign s_axi_rresp  = rresp_reg;
   assign s_axi_rdata  = rdata_reg;
endmodule

// >>> logic/srd_top.sv
// standby-release detect configuration: registers, channel detectors and interrupt
//
// Design decisions made here: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
module srd_top
   import srd_pkg::*;
(
   input  wire logic                clock_i,
   input  wire logic                rst_b_i,
   input  wire logic [NUM_CH-1:0]   ext_request_i,
   output logic [NUM_CH-1:0]        release_request_o,
   output logic                     irq_o,
   input  wire logic [ADDR_W-1:0]   s_axi_awaddr,
   input  wire logic                s_axi_awvalid,
   output logic                     s_axi_awready,
   input  wire logic [DATA_W-1:0]   s_axi_wdata,
   input  wire logic [3:0]          s_axi_wstrb,
   input  wire logic                s_axi_wvalid,
   output logic                     s_axi_wready,
   output logic [1:0]               s_axi_bresp,
   output logic                     s_axi_bvalid,
   input  wire logic                s_axi_bready,
   input  wire logic [ADDR_W-1:0]   s_axi_araddr,
   input  wire logic                s_axi_arvalid,
   output logic                     s_axi_arready,
   output logic [DATA_W-1:0]        s_axi_rdata,
   output logic [1:0]               s_axi_rresp,
   output logic                     s_axi_rvalid,
   input  wire logic                s_axi_rready
);
   logic                wr_en;
   logic [ADDR_W-1:0]   wr_addr;
   logic [DATA_W-1:0]   wr_data;
   logic [3:0]          wr_strb;
   logic [ADDR_W-1:0]   rd_addr;
   logic [DATA_W-1:0]   rd_data;
   logic                rd_ok;
   logic                wr_ok;

   logic [2:0]          mode_reg    [NUM_CH];
   logic [2:0]          mode_next   [NUM_CH];
   logic [NUM_CH-1:0]   en_reg,     en_next;
   logic [NUM_CH-1:0]   pend_reg,   pend_next;
   logic [NUM_CH-1:0]   mask_reg,   mask_next;
   logic [NUM_CH-1:0]   clear_ch;
   logic [NUM_CH-1:0]   req;
   logic [1:0]          edge_st     [NUM_CH];

   // byte lane of one channel inside the control word
   function automatic logic [LANE_W-1:0] lane_of(input logic [DATA_W-1:0] w, input int ch);
      lane_of = w[ch*LANE_W +: LANE_W];
   endfunction

   function automatic logic addr_known(input logic [ADDR_W-1:0] a);
      addr_known = (a == OFS_DETECT_CTRL) || (a == OFS_PEND_STATUS) ||
                   (a == OFS_PEND_MASK)   || (a == OFS_CLEAR);
   endfunction

   srd_axil_slave u_bus (
      .clock_i       (clock_i),
      .rst_b_i       (rst_b_i),
      .s_axi_awaddr  (s_axi_awaddr),
      .s_axi_awvalid (s_axi_awvalid),
      .s_axi_awready (s_axi_awready),
      .s_axi_wdata   (s_axi_wdata),
      .s_axi_wstrb   (s_axi_wstrb),
      .s_axi_wvalid  (s_axi_wvalid),
      .s_axi_wready  (s_axi_wready),
      .s_axi_bresp   (s_axi_bresp),
      .s_axi_bvalid  (s_axi_bvalid),
      .s_axi_bready  (s_axi_bready),
      .s_axi_araddr  (s_axi_araddr),
      .s_axi_arvalid (s_axi_arvalid),
      .s_axi_arready (s_axi_arready),
      .s_axi_rdata   (s_axi_rdata),
      .s_axi_rresp   (s_axi_rresp),
      .s_axi_rvalid  (s_axi_rvalid),
      .s_axi_rready  (s_axi_rready),
      .wr_en_o       (wr_en),
      .wr_addr_o     (wr_addr),
      .wr_data_o     (wr_data),
      .wr_strb_o     (wr_strb),
      .wr_ok_i       (wr_ok),
      .rd_addr_o     (rd_addr),
      .rd_data_i     (rd_data),
      .rd_ok_i       (rd_ok)
   );

   assign wr_ok = addr_known(wr_addr);
   assign rd_ok = addr_known(rd_addr);

   // a write of one to the clear register drops the pending bit and the edge record
   assign clear_ch = (wr_en && wr_addr == OFS_CLEAR && wr_strb[0]) ? wr_data[NUM_CH-1:0] : '0;

   genvar g;
   generate
      for (g = 0; g < NUM_CH; g++) begin : g_ch
         srd_edge_det u_det (
            .clock_i   (clock_i),
            .rst_b_i   (rst_b_i),
            .pin_i     (ext_request_i[g]),
            .mode_i    (mode_reg[g]),
            .enable_i  (en_reg[g]),
            .clear_i   (clear_ch[g]),
            .request_o (req[g]),
            .edge_o    (edge_st[g])
         );
      end
   endgenerate

   always_comb begin
      logic [LANE_W-1:0] lane;
      lane      = '0;
      en_next   = en_reg;
      mask_next = mask_reg;
      for (int c = 0; c < NUM_CH; c++) begin
         mode_next[c] = mode_reg[c];
      end
      if (wr_en && wr_addr == OFS_DETECT_CTRL) begin
         // mode and enable sharing one write is the caller's fault; both are stored as written
         for (int c = 0; c < NUM_CH; c++) begin
            if (wr_strb[c]) begin
               lane         = lane_of(wr_data, c);
               mode_next[c] = lane[MODE_LSB +: 3];
               en_next[c]   = lane[EN_BIT];
            end
         end
      end
      if (wr_en && wr_addr == OFS_PEND_MASK && wr_strb[0]) begin
         mask_next = wr_data[NUM_CH-1:0];
      end
      // set wins over a same-cycle clear
      pend_next = (pend_reg & ~clear_ch) | req;
   end

   always_ff @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         for (int c = 0; c < NUM_CH; c++) begin
            mode_reg[c] <= MODE_RESET;
         end
         en_reg   <= '0;
         pend_reg <= '0;
         mask_reg <= '0;
      end else begin
         for (int c = 0; c < NUM_CH; c++) begin
            mode_reg[c] <= mode_next[c];
         end
         en_reg   <= en_next;
         pend_reg <= pend_next;
         mask_reg <= mask_next;
      end
   end

   always_comb begin
      rd_data = '0;
      unique case (rd_addr)
         OFS_DETECT_CTRL: begin
            for (int c = 0; c < NUM_CH; c++) begin
               rd_data[c*LANE_W + MODE_LSB +: 3] = mode_reg[c];
               rd_data[c*LANE_W + STAT_LSB +: 2] = edge_st[c];
               rd_data[c*LANE_W + UNDEF_BIT]     = UNDEF_VALUE;
               rd_data[c*LANE_W + EN_BIT]        = en_reg[c];
            end
         end
         OFS_PEND_STATUS: rd_data[NUM_CH-1:0] = pend_reg;
         OFS_PEND_MASK:   rd_data[NUM_CH-1:0] = mask_reg;
         default:         rd_data = '0;
      endcase
   end

   assign release_request_o = pend_reg;
   assign irq_o             = |(pend_reg & mask_reg);
endmodule

// >>> tb/srd_checker.sv
// port-level assertions for the standby-release detect block
`timescale 1ns/100ps
module srd_checker
(
   input wire logic                       clock_i,
   input wire logic                       rst_b_i,
   input wire logic [srd_pkg::NUM_CH-1:0] release_request_o,
   input wire logic                       irq_o,
   input wire logic                       s_axi_awvalid,
   input wire logic                       s_axi_awready,
   input wire logic                       s_axi_wvalid,
   input wire logic                       s_axi_wready,
   input wire logic                       s_axi_bvalid,
   input wire logic                       s_axi_bready,
   input wire logic [1:0]                 s_axi_bresp,
   input wire logic [srd_pkg::ADDR_W-1:0] s_axi_araddr,
   input wire logic                       s_axi_arvalid,
   input wire logic                       s_axi_arready,
   input wire logic                       s_axi_rvalid,
   input wire logic                       s_axi_rready,
   input wire logic [srd_pkg::DATA_W-1:0] s_axi_rdata,
   input wire logic [1:0]                 s_axi_rresp
);
   import srd_pkg::*;
   logic [ADDR_W-1:0] rd_addr_reg;
   logic              mapped;
   default clocking @(posedge clock_i); endclocking
   default disable iff (!rst_b_i);
   // the data phase carries no address, so keep the one that was taken
   always_ff @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) rd_addr_reg <= '0;
      else if (s_axi_arvalid && s_axi_arready) rd_addr_reg <= s_axi_araddr;
   end
   assign mapped = rd_addr_reg inside {OFS_DETECT_CTRL, OFS_PEND_STATUS, OFS_PEND_MASK, OFS_CLEAR};
   a_irq_needs_pend: assert property (irq_o |-> |release_request_o)
      else $error("irq without pending request");
   a_pend_only_clr: assert property (|($past(release_request_o) & ~release_request_o) |-> s_axi_bvalid)
      else $error("pending request dropped without a write");
   a_irq_fall_write: assert property ($fell(irq_o) |-> s_axi_bvalid)
      else $error("interrupt dropped without a write");
   a_ctrl_rsvd_zero: assert property (s_axi_rvalid && rd_addr_reg == OFS_DETECT_CTRL
      |-> (s_axi_rdata & 32'h8282_8282) == 32'h0000_0000 && s_axi_rresp == RESP_OKAY)
      else $error("reserved control bits not zero");
   a_unmapped_err: assert property (s_axi_rvalid && !mapped |-> s_axi_rresp == RESP_SLVERR && s_axi_rdata == '0)
      else $error("unmapped read not refused");
   a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
      else $error("write response late");
   a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read response late");
   a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response not held");
   a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data not held");
   a_busy_refuse: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write taken while response pending");
   a_rbusy_refuse: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read taken while data pending");
   c_irq: cover property (irq_o);
   c_clear: cover property ($fell(|release_request_o));
   c_err: cover property (s_axi_rvalid && s_axi_rresp == RESP_SLVERR);
endmodule

// >>> tb/srd_pin_model.sv
// far-side model: the four external request pins
`timescale 1ns/100ps
module srd_pin_model
(
   input  wire logic                       clock_i,
   input  wire logic [srd_pkg::NUM_CH-1:0] level_i,
   output logic      [srd_pkg::NUM_CH-1:0] pin_o
);
   // pins move just after an edge, as a synchronous source would
   always @(posedge clock_i) pin_o <= level_i;
endmodule

// >>> tb/tb.sv
// self-checking bench for the standby-release detect block
`timescale 1ns/100ps
module tb;
   import srd_pkg::*;
   logic clock_i, rst_b_i, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, t;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq_o;
   logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
   logic [DATA_W-1:0] s_axi_wdata, s_axi_rdata, rd, exp;
   logic [3:0]        s_axi_wstrb, st;
   logic [1:0]        s_axi_bresp, s_axi_rresp, rsp;
   logic [2:0]        md;
   logic [NUM_CH-1:0] ext_request_i, release_request_o, pin_level;
   int                fail_count, compares, c;
   int                cycles = 0;
   srd_top u_srd_top (.*);
   srd_pin_model u_srd_pin_model (.clock_i(clock_i), .level_i(pin_level), .pin_o(ext_request_i));
   initial begin
      clock_i = 1'b0;
      forever #4 clock_i = ~clock_i;
   end
   task automatic test_done();
      $display("mismatches %0d compares %0d", fail_count, compares);
      if (fail_count == 0 && compares > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   always @(posedge clock_i) begin
      cycles <= cycles + 1;
      if (cycles == 30000) begin
         fail_count++;
         $display("BAD %0t timeout", $time);
         test_done();
      end
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] e, input string m);
      compares++;
      if (got !== e) begin
         fail_count++;
         $display("BAD %0t %s got %h exp %h", $time, m, got, e);
      end
   endtask
   // handshakes are judged at the falling edge, where the slave's answer has settled
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
      logic ta, tw, tk;
      @(posedge clock_i);
      s_axi_awaddr <= a; s_axi_wdata <= d; s_axi_wstrb <= s;
      s_axi_awvalid <= 1'b1; s_axi_wvalid <= 1'b1; s_axi_bready <= 1'b1;
      do begin
         @(negedge clock_i);
         ta = s_axi_awvalid && s_axi_awready; tw = s_axi_wvalid && s_axi_wready;
         tk = s_axi_bvalid; rsp = s_axi_bresp;
         @(posedge clock_i);
         if (ta) s_axi_awvalid <= 1'b0;
         if (tw) s_axi_wvalid <= 1'b0;
      end while (!tk);
      s_axi_bready <= 1'b0;
   endtask
   task automatic rdr(input logic [7:0] a);
      logic ta, tk;
      @(posedge clock_i);
      s_axi_araddr <= a; s_axi_arvalid <= 1'b1; s_axi_rready <= 1'b1;
      do begin
         @(negedge clock_i);
         ta = s_axi_arvalid && s_axi_arready; tk = s_axi_rvalid; rd = s_axi_rdata; rsp = s_axi_rresp;
         @(posedge clock_i);
         if (ta) s_axi_arvalid <= 1'b0;
      end while (!tk);
      s_axi_rready <= 1'b0;
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clock_i);
   endtask
   task automatic pin(input logic v);
      @(posedge clock_i);
      pin_level[c] <= v;
      cyc(5);
   endtask
   task automatic sts(input logic [1:0] e);
      rdr(OFS_DETECT_CTRL);
      chk(rd[8*c+STAT_LSB +: 2], e, "edge status");
   endtask
   function automatic logic [7:0] lane(input logic [2:0] m, input logic e);
      return {1'b0, m, 3'h0, e};
   endfunction
   initial begin
      rst_b_i = 1'b0; s_axi_awvalid = 1'b0; s_axi_wvalid = 1'b0; s_axi_bready = 1'b0;
      s_axi_arvalid = 1'b0; s_axi_rready = 1'b0; s_axi_awaddr = '0; s_axi_araddr = '0;
      s_axi_wdata = '0; s_axi_wstrb = '0; pin_level = '0; fail_count = 0; compares = 0; c = 0;
      void'($urandom(65461));
      cyc(6);
      rst_b_i <= 1'b1;
      rdr(OFS_DETECT_CTRL);
      chk(rd, {4{lane(MODE_RESET, 1'b0)}}, "reset value");
      chk({irq_o, release_request_o}, 0, "reset outputs");
      for (int k = 0; k < 4; k++) begin
         // only legal mode codes, with enables left off
         for (int i = 0; i < NUM_CH; i++) exp[8*i +: 8] = lane(3'($urandom_range(4)), 1'b0);
         wr(OFS_DETECT_CTRL, exp | ($urandom() & 32'h8E8E_8E8E), 4'hF);
         chk(rsp, RESP_OKAY, "write response");
         rdr(OFS_DETECT_CTRL);
         chk(rsp, RESP_OKAY, "read response");
         chk(rd, exp, "field layout");
      end
      wr(8'h10, 32'hFFFF_FFFF, 4'hF);
      chk(rsp, RESP_SLVERR, "unmapped write");
      rdr(8'h10);
      chk(rd, 0, "unmapped read data");
      chk(rsp, RESP_SLVERR, "unmapped read");
      for (int m = 0; m <= 4; m++) begin
         c = $urandom_range(NUM_CH - 1);
         md = 3'(m);
         t = (md == MODE_HIGH || md == MODE_RISE || md == MODE_BOTH);
         st = 4'h1 << c;
         wr(OFS_DETECT_CTRL, 32'(lane(md, 1'b0)) << (8*c), st);
         pin(t);
         wr(OFS_CLEAR, 32'(st), 4'h1);
         cyc(5);
         chk(release_request_o, 0, "disabled input");
         pin(!t);
         wr(OFS_DETECT_CTRL, 32'(lane(md, 1'b1)) << (8*c), st);
         cyc(5);
         chk(release_request_o, 0, "idle level");
         pin(t);
         chk(release_request_o, 32'(st), "request");
         rdr(OFS_PEND_STATUS);
         chk(rd, 32'(st), "pending status");
         if (md == MODE_BOTH) begin
            sts(EDGE_RISE);
            wr(OFS_CLEAR, 32'(st), 4'h1);
            sts(EDGE_NONE);
            pin(1'b0);
            sts(EDGE_FALL);
            pin(1'b1);
            sts(EDGE_BOTH);
         end
         wr(OFS_PEND_MASK, 32'(st), 4'h1);
         rdr(OFS_PEND_MASK);
         chk(rd, 32'(st), "mask readback");
         chk(irq_o, 1, "irq raised");
         wr(OFS_PEND_MASK, 0, 4'h1);
         chk(irq_o, 0, "irq masked");
         wr(OFS_PEND_MASK, 32'(st), 4'h1);
         pin(!t);
         wr(OFS_CLEAR, 32'(st), 4'h1);
         chk({irq_o, release_request_o}, 0, "cleared");
         wr(OFS_DETECT_CTRL, 32'(lane(md, 1'b0)) << (8*c), st);
      end
      test_done();
   end
endmodule
bind srd_top srd_checker u_srd_checker (.*);
